// >>> irq_dispatch_pkg.sv
package irq_dispatch_pkg;

    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_MAIN_CTRL = 8'h00;
    localparam logic [7:0] OFS_FLAG_A = 8'h04;
    localparam logic [7:0] OFS_FLAG_B = 8'h08;
    localparam logic [7:0] OFS_FLAG_C = 8'h0c;
    localparam logic [7:0] OFS_ENABLE_A = 8'h10;
    localparam logic [7:0] OFS_ENABLE_B = 8'h14;
    localparam logic [7:0] OFS_ENABLE_C = 8'h18;
    localparam logic [7:0] OFS_OPTION = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;

    // ---------------------------------------------------------------
    // Main control and option register fields, reset values
    // ---------------------------------------------------------------
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_PERIPH_GROUP_EN = 6;
    localparam int BIT_TMR_OVF_EN = 5;
    localparam int BIT_EXT_PIN_EN = 4;
    localparam int BIT_IOC_EN = 3;
    localparam int BIT_TMR_OVF_FLAG = 2;
    localparam int BIT_EXT_PIN_FLAG = 1;
    localparam int BIT_IOC_FLAG = 0;
    localparam int BIT_EDGE_SELECT = 0;
    localparam logic [7:0] MAIN_CTRL_RST = 8'h00;
    localparam logic [7:0] PERIPH_RST = 8'h00;
    localparam logic EDGE_SELECT_RST = 1'h1;

    // ---------------------------------------------------------------
    // Core timing and vector
    // ---------------------------------------------------------------
    localparam int PC_W = 15;
    localparam logic [PC_W-1:0] VECTOR_ADDR = 15'h0004;
    localparam logic [1:0] PHASE_Q1 = 2'h0;
    localparam logic [1:0] PHASE_Q4 = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAKE,
        ST_FLUSH,
        ST_SAVE,
        ST_VECTOR
    } dispatch_state_t;

endpackage

// >>> irq_flag_reg.sv
`timescale 1ns/1ps

module irq_flag_reg #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Hardware set and software write
    input wire logic [W-1:0] setVec,
    input wire logic wrEn,
    input wire logic [W-1:0] wrData,
    // Flags
    output logic [W-1:0] flags
);

    logic [W-1:0] flags_r;
    logic [W-1:0] flags_nxt;

    // Set wins over a simultaneous software clear
    assign flags_nxt = (wrEn ? wrData : flags_r) | setVec;
    assign flags = flags_r;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

endmodule // irq_flag_reg

// >>> cpu_interrupt_dispatch.sv
`timescale 1ns/1ps

module cpu_interrupt_dispatch
    import irq_dispatch_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Event sources
    input wire logic tmrOvfEvent,
    input wire logic iocAnyPending,
    input wire logic [7:0] periphEventA,
    input wire logic [7:0] periphEventB,
    input wire logic [7:0] periphEventC,
    input wire logic extIrqPin,
    // Instruction sequencer
    input wire logic [PC_W-1:0] pcCurrent,
    input wire logic retfieExec,
    input wire logic sleepActive,
    output logic [1:0] cyclePhase,
    output logic irqRequest,
    output logic wakeRequest,
    output logic flushPrefetch,
    output logic pushPc,
    output logic [PC_W-1:0] pushPcValue,
    output logic saveShadow,
    output logic loadVector,
    output logic [PC_W-1:0] vectorAddr,
    output logic popPc,
    output logic restoreShadow,
    output logic globalIrqEnable
);

    // ---------------------------------------------------------------
    // Bus slave
    // ---------------------------------------------------------------
    logic wrPend_r;
    logic [7:0] wrAddr_r;
    logic [31:0] hrdata_r;
    logic [31:0] rdMux;
    wire addrPhase = hsel && htrans[1] && hready;
    wire wrCtrl = wrPend_r && (wrAddr_r == OFS_MAIN_CTRL);
    wire wrFlagA = wrPend_r && (wrAddr_r == OFS_FLAG_A);
    wire wrFlagB = wrPend_r && (wrAddr_r == OFS_FLAG_B);
    wire wrFlagC = wrPend_r && (wrAddr_r == OFS_FLAG_C);
    wire wrEnA = wrPend_r && (wrAddr_r == OFS_ENABLE_A);
    wire wrEnB = wrPend_r && (wrAddr_r == OFS_ENABLE_B);
    wire wrEnC = wrPend_r && (wrAddr_r == OFS_ENABLE_C);
    wire wrOption = wrPend_r && (wrAddr_r == OFS_OPTION);

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
        end else begin
            wrPend_r <= addrPhase && hwrite;
            wrAddr_r <= haddr[7:0];
            if (addrPhase && !hwrite) begin
                hrdata_r <= rdMux;
            end
        end
    end

    // ---------------------------------------------------------------
    // Instruction cycle phase
    // ---------------------------------------------------------------
    logic [1:0] phase_r;
    wire atQ1 = (phase_r == PHASE_Q1);
    wire atQ4 = (phase_r == PHASE_Q4);
    assign cyclePhase = phase_r;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            phase_r <= PHASE_Q1;
        end else begin
            phase_r <= phase_r + 2'h1;
        end
    end

    // ---------------------------------------------------------------
    // Main control register
    // ---------------------------------------------------------------
    logic [7:0] mainCtrl_r;
    logic [7:0] mainCtrl_nxt;
    logic edgeSel_r;
    logic gie_r;
    logic gie_nxt;
    logic takeIrq;
    wire peripheral_group_irq_enable = mainCtrl_r[BIT_PERIPH_GROUP_EN];
    wire extFlag = mainCtrl_r[BIT_EXT_PIN_FLAG];
    wire tmrFlag = mainCtrl_r[BIT_TMR_OVF_FLAG];

    // External pin: two-flop sync, then edge detect
    logic pinMeta_r;
    logic pinSync_r;
    logic pinLast_r;
    logic extEdgePend_r;
    wire pinRise = pinSync_r && !pinLast_r;
    wire pinFall = !pinSync_r && pinLast_r;
    wire pinEdge = edgeSel_r ? pinRise : pinFall;
    // Flag may only set in the fourth or first phase
    wire extSetWin = atQ4 || atQ1;
    wire extSet = (pinEdge || extEdgePend_r) && extSetWin;

    always_ff @(posedge mclk) begin
        // Chain shifts through reset, so a pin held high gives no false edge after it
        pinMeta_r <= extIrqPin;
        pinSync_r <= pinMeta_r;
        pinLast_r <= pinSync_r;
        if (sys_rst) begin
            extEdgePend_r <= 1'b0;
        end else begin
            extEdgePend_r <= (pinEdge || extEdgePend_r) && !extSetWin;
        end
    end

    // Flags: write value, hardware set ORed on top; IOC flag mirrors sources
    always_comb begin
        mainCtrl_nxt = mainCtrl_r;
        if (wrCtrl) begin
            mainCtrl_nxt = hwdata[7:0];
        end
        mainCtrl_nxt[BIT_GLOBAL_EN] = 1'b0;
        mainCtrl_nxt[BIT_TMR_OVF_FLAG] = mainCtrl_nxt[BIT_TMR_OVF_FLAG] | tmrOvfEvent;
        mainCtrl_nxt[BIT_EXT_PIN_FLAG] = mainCtrl_nxt[BIT_EXT_PIN_FLAG] | extSet;
        mainCtrl_nxt[BIT_IOC_FLAG] = iocAnyPending;
    end

    // Global enable: taking clears, return sets, else software
    always_comb begin
        gie_nxt = gie_r;
        if (wrCtrl) begin
            gie_nxt = hwdata[BIT_GLOBAL_EN];
        end
        if (retfieExec) begin
            gie_nxt = 1'b1;
        end
        if (takeIrq) begin
            gie_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mainCtrl_r <= MAIN_CTRL_RST;
            gie_r <= 1'b0;
            edgeSel_r <= EDGE_SELECT_RST;
        end else begin
            mainCtrl_r <= mainCtrl_nxt;
            gie_r <= gie_nxt;
            if (wrOption) begin
                edgeSel_r <= hwdata[BIT_EDGE_SELECT];
            end
        end
    end

    // ---------------------------------------------------------------
    // Peripheral flag and enable registers
    // ---------------------------------------------------------------
    logic [7:0] flagA;
    logic [7:0] flagB;
    logic [7:0] flagC;
    logic [7:0] enA_r;
    logic [7:0] enB_r;
    logic [7:0] enC_r;

    irq_flag_reg #(.W(8)) u_flag_a (
        .mclk(mclk), .sys_rst(sys_rst), .setVec(periphEventA),
        .wrEn(wrFlagA), .wrData(hwdata[7:0]), .flags(flagA)
    );
    irq_flag_reg #(.W(8)) u_flag_b (
        .mclk(mclk), .sys_rst(sys_rst), .setVec(periphEventB),
        .wrEn(wrFlagB), .wrData(hwdata[7:0]), .flags(flagB)
    );
    irq_flag_reg #(.W(8)) u_flag_c (
        .mclk(mclk), .sys_rst(sys_rst), .setVec(periphEventC),
        .wrEn(wrFlagC), .wrData(hwdata[7:0]), .flags(flagC)
    );

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            enA_r <= PERIPH_RST;
            enB_r <= PERIPH_RST;
            enC_r <= PERIPH_RST;
        end else begin
            if (wrEnA) begin
                enA_r <= hwdata[7:0];
            end
            if (wrEnB) begin
                enB_r <= hwdata[7:0];
            end
            if (wrEnC) begin
                enC_r <= hwdata[7:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // Request gating
    // ---------------------------------------------------------------
    wire corePend = (tmrFlag && mainCtrl_r[BIT_TMR_OVF_EN])
        || (extFlag && mainCtrl_r[BIT_EXT_PIN_EN])
        || (mainCtrl_r[BIT_IOC_FLAG] && mainCtrl_r[BIT_IOC_EN]);
    wire periPend = peripheral_group_irq_enable && (|((flagA & enA_r) | (flagB & enB_r) | (flagC & enC_r)));
    wire anyEnabled = corePend || periPend;
    // Level while an enabled flag remains; an uncleared flag re-fires after return
    assign irqRequest = gie_r && anyEnabled;
    // Wake needs no global enable
    assign wakeRequest = sleepActive && anyEnabled;
    assign globalIrqEnable = gie_r;
    assign vectorAddr = VECTOR_ADDR;

    // ---------------------------------------------------------------
    // Dispatch sequence, one state per instruction cycle
    // ---------------------------------------------------------------
    dispatch_state_t state_r;
    dispatch_state_t state_nxt;
    logic [PC_W-1:0] pushPcValue_r;
    logic flush_r;
    logic push_r;
    logic load_r;
    logic ret_r;

    // Decided only at Q1, never on instruction length, so latency is fixed
    assign takeIrq = atQ1 && irqRequest && !sleepActive && (state_r == ST_IDLE);

    always_comb begin
        state_nxt = state_r;
        if (atQ1) begin
            unique case (state_r)
                ST_IDLE: begin
                    if (takeIrq) begin
                        state_nxt = ST_FLUSH;
                    end else if (sleepActive && irqRequest) begin
                        state_nxt = ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    state_nxt = ST_IDLE;
                end
                ST_FLUSH: begin
                    state_nxt = ST_SAVE;
                end
                ST_SAVE: begin
                    state_nxt = ST_VECTOR;
                end
                ST_VECTOR: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
            pushPcValue_r <= '0;
            flush_r <= 1'b0;
            push_r <= 1'b0;
            load_r <= 1'b0;
            ret_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            flush_r <= takeIrq;
            push_r <= atQ1 && (state_r == ST_FLUSH);
            load_r <= atQ1 && (state_r == ST_SAVE);
            ret_r <= retfieExec;
            if (atQ1 && (state_r == ST_FLUSH)) begin
                pushPcValue_r <= pcCurrent;
            end
        end
    end

    assign flushPrefetch = flush_r;
    assign pushPc = push_r;
    assign saveShadow = push_r;
    assign pushPcValue = pushPcValue_r;
    assign loadVector = load_r;
    assign popPc = ret_r;
    assign restoreShadow = ret_r;

    // Register read mux; a read right after a write to it sees the old value
    always_comb begin
        rdMux = 32'h0000_0000;
        unique case (haddr[7:0])
            OFS_MAIN_CTRL: rdMux[7:0] = {gie_r, mainCtrl_r[6:0]};
            OFS_FLAG_A: rdMux[7:0] = flagA;
            OFS_FLAG_B: rdMux[7:0] = flagB;
            OFS_FLAG_C: rdMux[7:0] = flagC;
            OFS_ENABLE_A: rdMux[7:0] = enA_r;
            OFS_ENABLE_B: rdMux[7:0] = enB_r;
            OFS_ENABLE_C: rdMux[7:0] = enC_r;
            OFS_OPTION: rdMux[0] = edgeSel_r;
            OFS_STATUS: rdMux[5:0] = {state_r, phase_r, irqRequest};
            default: rdMux = 32'h0000_0000;
        endcase
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    sequence s_saveStep;
        pushPc && saveShadow && !flushPrefetch;
    endsequence
    sequence s_vectorStep;
        loadVector && (vectorAddr == VECTOR_ADDR);
    endsequence

    property p_resetOff;
        @(posedge mclk) sys_rst |=> !gie_r && !irqRequest && (state_r == ST_IDLE);
    endproperty
    a_resetOff: assert property (p_resetOff) else $error("enable not off after reset");

    property p_gate;
        @(posedge mclk) disable iff (sys_rst) irqRequest && !peripheral_group_irq_enable |-> corePend;
    endproperty
    a_gate: assert property (p_gate) else $error("request without enables");

    property p_flagSet;
        @(posedge mclk) disable iff (sys_rst) tmrOvfEvent || (|periphEventA) |=>
            (!$past(tmrOvfEvent) || tmrFlag) && (($past(periphEventA) & ~flagA) == 8'h00);
    endproperty
    a_flagSet: assert property (p_flagSet) else $error("event flag not set");

    property p_take;
        @(posedge mclk) disable iff (sys_rst) takeIrq |=> flushPrefetch && !gie_r;
    endproperty
    a_take: assert property (p_take) else $error("take without flush");

    property p_sequence;
        @(posedge mclk) disable iff (sys_rst) flushPrefetch |-> ##4 s_saveStep ##4 s_vectorStep;
    endproperty
    a_sequence: assert property (p_sequence) else $error("dispatch steps out of order");

    property p_latency;
        @(posedge mclk) disable iff (sys_rst) takeIrq |-> ##9 loadVector ##4 (state_r == ST_IDLE);
    endproperty
    a_latency: assert property (p_latency) else $error("vector latency wrong");

    property p_blocked;
        @(posedge mclk) disable iff (sys_rst) !globalIrqEnable |=> !flushPrefetch;
    endproperty
    a_blocked: assert property (p_blocked) else $error("redirect while disabled");

    property p_return;
        @(posedge mclk) disable iff (sys_rst) retfieExec && !takeIrq |=> gie_r && popPc && restoreShadow;
    endproperty
    a_return: assert property (p_return) else $error("return did not restore");

    property p_q1Only;
        @(posedge mclk) disable iff (sys_rst) (state_r == ST_IDLE) && !atQ1 |=> (state_r == ST_IDLE);
    endproperty
    a_q1Only: assert property (p_q1Only) else $error("dispatch outside first phase");

    property p_extWindow;
        @(posedge mclk) disable iff (sys_rst) $rose(extFlag) && !$past(wrCtrl) |->
            ($past(phase_r) == PHASE_Q4) || ($past(phase_r) == PHASE_Q1);
    endproperty
    a_extWindow: assert property (p_extWindow) else $error("pin flag set outside window");

    property p_wake;
        @(posedge mclk) disable iff (sys_rst) (state_r == ST_IDLE) ##1 (state_r == ST_WAKE) |->
            ##3 (state_r == ST_WAKE) ##1 (state_r == ST_IDLE);
    endproperty
    a_wake: assert property (p_wake) else $error("wake skipped next instruction");

endmodule // cpu_interrupt_dispatch

// >>> seq_model.sv
`timescale 1ns/1ps

module seq_model
    import irq_dispatch_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Dispatch side
    input wire logic [1:0] cyclePhase,
    input wire logic flushPrefetch,
    input wire logic pushPc,
    input wire logic [PC_W-1:0] pushPcValue,
    input wire logic loadVector,
    input wire logic [PC_W-1:0] vectorAddr,
    input wire logic popPc,
    // Program counter
    output logic [PC_W-1:0] pcCurrent
);
    logic [PC_W-1:0] stackTop_r;
    logic stall_r;

    // ---------------------------------------------------------------
    // Fetch: frozen from flush to vector load, so the pushed PC is known
    // ---------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pcCurrent <= 15'h0100;
            stackTop_r <= 15'h0000;
            stall_r <= 1'b0;
        end else begin
            if (flushPrefetch) begin
                stall_r <= 1'b1;
            end
            if (pushPc) begin
                stackTop_r <= pushPcValue;
            end
            if (loadVector) begin
                stall_r <= 1'b0;
                pcCurrent <= vectorAddr;
            end else if (popPc) begin
                pcCurrent <= stackTop_r;
            end else if (!stall_r && cyclePhase == PHASE_Q4) begin
                pcCurrent <= pcCurrent + 15'h0001;
            end
        end
    end
endmodule // seq_model

// >>> tb_cpu_interrupt_dispatch.sv
`timescale 1ns/1ps

module tb_cpu_interrupt_dispatch
    import irq_dispatch_pkg::*;
;
    logic mclk = 1'b0, sys_rst = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0, cyclePhase;
    logic [2:0] hsize = 3'h2;
    logic tmrOvfEvent = 1'b0, extIrqPin = 1'b0, retfieExec = 1'b0, sleepActive = 1'b0;
    logic [7:0] evA = 8'h00, evB = 8'h00, evC = 8'h00;
    logic iocPend = 1'b0;
    logic [PC_W-1:0] pcCurrent, pushPcValue, vectorAddr, pcSaved;
    logic irqRequest, wakeRequest, flushPrefetch, pushPc, saveShadow, loadVector;
    logic popPc, restoreShadow, globalIrqEnable;
    int bad_count = 0, check_count = 0, n;

    assign hready = hreadyout;
    always #5 mclk = ~mclk;

    cpu_interrupt_dispatch i_cpu_interrupt_dispatch (.mclk(mclk), .sys_rst(sys_rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .tmrOvfEvent(tmrOvfEvent), .iocAnyPending(iocPend),
        .periphEventA(evA), .periphEventB(evB), .periphEventC(evC), .extIrqPin(extIrqPin),
        .pcCurrent(pcCurrent), .retfieExec(retfieExec), .sleepActive(sleepActive),
        .cyclePhase(cyclePhase), .irqRequest(irqRequest), .wakeRequest(wakeRequest),
        .flushPrefetch(flushPrefetch), .pushPc(pushPc), .pushPcValue(pushPcValue),
        .saveShadow(saveShadow), .loadVector(loadVector), .vectorAddr(vectorAddr),
        .popPc(popPc), .restoreShadow(restoreShadow), .globalIrqEnable(globalIrqEnable));

    seq_model i_seq_model (.mclk(mclk), .sys_rst(sys_rst), .cyclePhase(cyclePhase),
        .flushPrefetch(flushPrefetch), .pushPc(pushPc), .pushPcValue(pushPcValue),
        .loadVector(loadVector), .vectorAddr(vectorAddr), .popPc(popPc),
        .pcCurrent(pcCurrent));

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task final_report;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge mclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(name, rd, exp);
        check("hresp", 32'(hresp), 32'h0);
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: return flushPrefetch;
            1: return pushPc;
            default: return loadVector;
        endcase
    endfunction

    // Bounded wait, samples after the edge has settled
    task automatic wait_on(input int w, input int limit, output int cnt);
        cnt = 0;
        while (pick(w) !== 1'b1 && cnt < limit) begin
            @(posedge mclk);
            #1;
            cnt++;
        end
        check("handshake", 32'(pick(w)), 32'h1);
    endtask

    task automatic return_from_irq_instr;
        @(posedge mclk);
        retfieExec <= 1'b1;
        @(posedge mclk);
        retfieExec <= 1'b0;
        #1;
        check("pop", {popPc, restoreShadow, globalIrqEnable}, 32'h7);
    endtask

    task automatic pulse_a;
        @(posedge mclk);
        evA <= 8'h08;
        @(posedge mclk);
        evA <= 8'h00;
        #1;
    endtask

    initial begin
        #300000;
        bad_count++;
        final_report();
    end

    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        rd_chk("main", OFS_MAIN_CTRL, 32'h0);
        rd_chk("option", OFS_OPTION, 32'h1);
        check("gie", 32'(globalIrqEnable), 32'h0);
        // Events with every enable clear still flag
        @(posedge mclk);
        tmrOvfEvent <= 1'b1;
        evB <= 8'h01;
        evC <= 8'h80;
        @(posedge mclk);
        tmrOvfEvent <= 1'b0;
        evB <= 8'h00;
        evC <= 8'h00;
        pulse_a();
        rd_chk("main", OFS_MAIN_CTRL, 32'h04);
        iocPend <= 1'b1;
        rd_chk("ioc", OFS_MAIN_CTRL, 32'h05);
        iocPend <= 1'b0;
        rd_chk("flagA", OFS_FLAG_A, 32'h08);
        rd_chk("flagB", OFS_FLAG_B, 32'h01);
        rd_chk("flagC", OFS_FLAG_C, 32'h80);
        rd_chk("unmapped", 8'h40, 32'h0);
        bus(1'b1, OFS_ENABLE_A, 32'h08);
        bus(1'b1, OFS_MAIN_CTRL, 32'h80);
        repeat (8) @(posedge mclk);
        #1;
        check("nogroup", {irqRequest, globalIrqEnable}, 32'h1);
        // Halted core: wake only, no take until it leaves halt
        sleepActive <= 1'b1;
        bus(1'b1, OFS_MAIN_CTRL, 32'hc0);
        repeat (8) @(posedge mclk);
        #1;
        check("wake", {wakeRequest, irqRequest, globalIrqEnable}, 32'h7);
        @(posedge mclk);
        sleepActive <= 1'b0;
        wait_on(0, 16, n);
        check("flush_gie", 32'(globalIrqEnable), 32'h0);
        pcSaved = pcCurrent;
        wait_on(1, 8, n);
        check("push", {saveShadow, 1'b0, pushPcValue}, {16'h1, 1'b0, pcSaved});
        wait_on(2, 8, n);
        check("vector", 32'(vectorAddr), 32'h0004);
        @(posedge mclk);
        #1;
        check("pc_vec", 32'(pcCurrent), 32'h0004);
        // Flag left set: request persists and is taken again
        return_from_irq_instr();
        @(posedge mclk);
        #1;
        check("pc_ret", 32'(pcCurrent), 32'(pcSaved));
        check("level", 32'(irqRequest), 32'h1);
        wait_on(0, 8, n);
        rd_chk("poll", OFS_FLAG_A, 32'h08);
        bus(1'b1, OFS_FLAG_A, 32'h0);
        wait_on(2, 16, n);
        return_from_irq_instr();
        check("cleared", 32'(irqRequest), 32'h0);
        // Synchronous event latency; vector executes the cycle after loadVector
        pulse_a();
        wait_on(2, 30, n);
        check("sync_lat", 32'(n >= 10 && n <= 15), 32'h1);
        bus(1'b1, OFS_FLAG_A, 32'h0);
        return_from_irq_instr();
        bus(1'b1, OFS_MAIN_CTRL, 32'h90);
        @(posedge mclk);
        extIrqPin <= 1'b1;
        @(posedge mclk);
        #1;
        wait_on(2, 40, n);
        check("async_lat", 32'(n >= 10 && n <= 19), 32'h1);
        rd_chk("pinflag", OFS_MAIN_CTRL, 32'h12);
        // Falling edge select
        bus(1'b1, OFS_OPTION, 32'h0);
        bus(1'b1, OFS_MAIN_CTRL, 32'h50);
        extIrqPin <= 1'b0;
        repeat (12) @(posedge mclk);
        rd_chk("fall", OFS_MAIN_CTRL, 32'h52);
        bus(1'b1, OFS_MAIN_CTRL, 32'h50);
        extIrqPin <= 1'b1;
        repeat (12) @(posedge mclk);
        rd_chk("rise", OFS_MAIN_CTRL, 32'h50);
        bus(1'b1, OFS_ENABLE_B, 32'h5a);
        rd_chk("enB", OFS_ENABLE_B, 32'h5a);
        // Second reset in mid-run
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        // Pin still high: a false edge after reset would set the pin flag
        repeat (8) @(posedge mclk);
        rd_chk("main_rst", OFS_MAIN_CTRL, 32'h0);
        rd_chk("opt_rst", OFS_OPTION, 32'h1);
        rd_chk("enA_rst", OFS_ENABLE_A, 32'h0);
        rd_chk("enB_rst", OFS_ENABLE_B, 32'h0);
        final_report();
    end
endmodule // tb_cpu_interrupt_dispatch
